// *** tmz_timer.sv ***
// Timer/counter with prescaler behind a classic Wishbone slave
`include "tmz_consts.svh"

module tmz_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device side
    input wire logic ext_count_pin_i,
    input wire logic sleep_i,
    output logic overflow_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_ff;
    tmz_pkg::tmz_ctrl_t ctrl;
    logic [7:0] irq_ff;
    logic [7:0] high_buf_ff;
    logic [15:0] count_ff;
    logic [7:0] presc_ff;
    logic [1:0] phase_ff;
    logic [1:0] hold_ff;
    logic [2:0] pin_sync_ff;
    tmz_pkg::tmz_bus_st_t bus_st_ff;
    logic req;
    logic wr_lane0;
    logic wr_low;
    logic rd_low;
    logic wr_ctrl;
    logic wr_high;
    logic wr_irq;
    logic cycle_tick;
    logic pin_rise;
    logic pin_fall;
    logic src_event;
    logic presc_done;
    logic [7:0] presc_last;
    logic inc;
    logic wrap;

    assign ctrl = tmz_pkg::tmz_ctrl_t'(ctrl_ff);

    ////////////////////////////////////////////////////////////////////////
    // Bus: every access acks one cycle after it is seen, then ack drops
    assign req = cyc_i && stb_i && (bus_st_ff == tmz_pkg::TMZ_IDLE);
    assign wr_lane0 = req && we_i && sel_i[0];
    assign wr_low = wr_lane0 && (adr_i == `TMZ_ADR_LOW);
    assign wr_high = wr_lane0 && (adr_i == `TMZ_ADR_HIGH);
    assign wr_ctrl = wr_lane0 && (adr_i == `TMZ_ADR_CTRL);
    assign wr_irq = wr_lane0 && (adr_i == `TMZ_ADR_IRQ);
    assign rd_low = req && !we_i && (adr_i == `TMZ_ADR_LOW);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st_ff <= tmz_pkg::TMZ_IDLE;
        end else begin
            case (bus_st_ff)
                tmz_pkg::TMZ_IDLE: begin
                    if (cyc_i && stb_i) begin
                        bus_st_ff <= tmz_pkg::TMZ_ACK;
                    end
                end
                tmz_pkg::TMZ_ACK: bus_st_ff <= tmz_pkg::TMZ_IDLE;
                default: bus_st_ff <= tmz_pkg::TMZ_IDLE;
            endcase
        end
    end

    assign ack_o = (bus_st_ff == tmz_pkg::TMZ_ACK);

    // Unmapped addresses read zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (req && !we_i) begin
            case (adr_i)
                `TMZ_ADR_LOW: dat_o <= {24'h0, count_ff[7:0]};
                `TMZ_ADR_HIGH: dat_o <= {24'h0, high_buf_ff};
                `TMZ_ADR_CTRL: dat_o <= {24'h0, ctrl_ff};
                `TMZ_ADR_IRQ: dat_o <= {24'h0, irq_ff};
                default: dat_o <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, all bits writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `TMZ_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= dat_i[7:0];
        end
    end

    // High byte buffer: written by software, refreshed by a low byte read in 16-bit width
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_buf_ff <= `TMZ_HIGH_RESET;
        end else if (wr_high) begin
            high_buf_ff <= dat_i[7:0];
        end else if (rd_low && !ctrl.width_select) begin
            high_buf_ff <= count_ff[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign cycle_tick = (phase_ff == `TMZ_CYCLE_DIV);

    // Pin synchroniser; stage 0 is read only by stage 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_ff <= 3'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], ext_count_pin_i};
        end
    end

    assign pin_rise = pin_sync_ff[1] && !pin_sync_ff[2];
    assign pin_fall = !pin_sync_ff[1] && pin_sync_ff[2];

    // Source selection and edge polarity
    always_comb begin
        if (ctrl.count_source_select) begin
            src_event = ctrl.source_edge_select ? pin_fall : pin_rise;
        end else begin
            src_event = cycle_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: hidden 8-bit count; ratio is 2^(sel+1)
    assign presc_last = 8'((9'h2 << ctrl.prescale_ratio_select) - 9'h1);
    // At or above the end: a smaller ratio takes effect at the next event
    assign presc_done = (presc_ff >= presc_last);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_ff <= 8'h0;
        end else if (wr_low && !ctrl.prescaler_bypass) begin
            presc_ff <= 8'h0;
        end else if (src_event && ctrl.run_control && !sleep_i
                     && !ctrl.prescaler_bypass) begin
            presc_ff <= presc_done ? 8'h0 : presc_ff + 8'h1;
        end
    end

    // Suppress counting for two instruction cycles after a low byte write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_ff <= 2'h0;
        end else if (wr_low) begin
            hold_ff <= `TMZ_WRITE_HOLD;
        end else if (cycle_tick && hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end
    end

    assign inc = ctrl.run_control && !sleep_i && hold_ff == 2'h0
                 && src_event && !wr_low
                 && (ctrl.prescaler_bypass || presc_done);

    assign wrap = inc && (ctrl.width_select ? count_ff[7:0] == 8'hFF
                                            : count_ff == 16'hFFFF);

    ////////////////////////////////////////////////////////////////////////
    // Counter; in 8-bit width the upper byte is left untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= 16'h0;
        end else if (wr_low) begin
            count_ff[7:0] <= dat_i[7:0];
            if (!ctrl.width_select) begin
                count_ff[15:8] <= high_buf_ff;
            end
        end else if (inc) begin
            if (ctrl.width_select) begin
                count_ff[7:0] <= count_ff[7:0] + 8'h1;
            end else begin
                count_ff <= count_ff + 16'h1;
            end
        end
    end

    // Interrupt control: bit 5 enable, bit 2 flag; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= `TMZ_IRQ_RESET;
        end else begin
            if (wr_irq) begin
                irq_ff <= dat_i[7:0];
            end
            if (wrap) begin
                irq_ff[`TMZ_IRQ_FLAG_BIT] <= 1'b1;
            end
        end
    end

    assign overflow_irq_o = irq_ff[`TMZ_IRQ_FLAG_BIT]
                            && irq_ff[`TMZ_IRQ_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_stop_holds;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl.run_control && !wr_low) |=> $stable(count_ff);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("counter moved while stopped");

    property p_sleep_holds;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_i && !wr_low) |=> $stable(count_ff);
    endproperty
    a_sleep_holds: assert property (p_sleep_holds)
        else $error("counter moved during sleep");

    property p_width8_upper;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.width_select && !wr_low) |=> $stable(count_ff[15:8]);
    endproperty
    a_width8_upper: assert property (p_width8_upper)
        else $error("upper byte moved in 8-bit width");

    property p_timer_step;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.run_control && !sleep_i && !ctrl.count_source_select
         && ctrl.prescaler_bypass && !ctrl.width_select && cycle_tick
         && hold_ff == 2'h0 && !wr_low && !wr_ctrl)
        |=> count_ff == $past(count_ff) + 16'h1;
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer did not step on instruction cycle");

    property p_write_hold;
        @(posedge clk_i) disable iff (rst_i)
        wr_low |=> (!inc) [*8];
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("count after low byte write too soon");

    property p_presc_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_low && !ctrl.prescaler_bypass) |=> presc_ff == 8'h0;
    endproperty
    a_presc_clear: assert property (p_presc_clear)
        else $error("prescaler not cleared by low byte write");

    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        wrap |=> irq_ff[`TMZ_IRQ_FLAG_BIT] && count_ff[7:0] == 8'h00;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("overflow flag not set on wrap");

    property p_irq_mask;
        @(posedge clk_i) disable iff (rst_i)
        !irq_ff[`TMZ_IRQ_EN_BIT] |-> !overflow_irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt raised while masked");

    property p_snapshot;
        @(posedge clk_i) disable iff (rst_i)
        (rd_low && !ctrl.width_select && !wr_high)
        |=> high_buf_ff == $past(count_ff[15:8]);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("high buffer not refreshed on low read");

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held for more than one cycle");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ctrl_ff == $past(dat_i[7:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");

    property p_load16;
        @(posedge clk_i) disable iff (rst_i)
        (wr_low && !ctrl.width_select)
        |=> count_ff == {$past(high_buf_ff), $past(dat_i[7:0])};
    endproperty
    a_load16: assert property (p_load16)
        else $error("16-bit load did not take the buffer");

    property p_presc_gate;
        @(posedge clk_i) disable iff (rst_i)
        (!ctrl.prescaler_bypass && !presc_done) |-> !inc;
    endproperty
    a_presc_gate: assert property (p_presc_gate)
        else $error("count stepped before prescaler period ended");

    property p_pin_only;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.count_source_select && !pin_rise && !pin_fall) |-> !inc;
    endproperty
    a_pin_only: assert property (p_pin_only)
        else $error("counter mode stepped without a pin edge");

    property p_fall_only;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.count_source_select && ctrl.source_edge_select && pin_rise)
        |-> !inc;
    endproperty
    a_fall_only: assert property (p_fall_only)
        else $error("rising pin edge counted with falling selected");

    property p_rise_only;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl.count_source_select && !ctrl.source_edge_select && pin_fall)
        |-> !inc;
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("falling pin edge counted with rising selected");

    c_wrap8: cover property (@(posedge clk_i) disable iff (rst_i)
        wrap && ctrl.width_select);
    c_wrap16: cover property (@(posedge clk_i) disable iff (rst_i)
        wrap && !ctrl.width_select);
    c_presc_step: cover property (@(posedge clk_i) disable iff (rst_i)
        inc && !ctrl.prescaler_bypass);
    c_pin_fall: cover property (@(posedge clk_i) disable iff (rst_i)
        inc && ctrl.count_source_select && ctrl.source_edge_select);

endmodule // tmz_timer

// *** tmz_consts.svh ***
// Register map, field positions, reset values and timing counts of the timer
`ifndef TMZ_CONSTS_SVH
`define TMZ_CONSTS_SVH

`define TMZ_ADR_LOW 4'h0
`define TMZ_ADR_HIGH 4'h4
`define TMZ_ADR_CTRL 4'h8
`define TMZ_ADR_IRQ 4'hC

`define TMZ_CTRL_RESET 8'hFF
`define TMZ_IRQ_RESET 8'h00
`define TMZ_HIGH_RESET 8'h00

`define TMZ_IRQ_EN_BIT 5
`define TMZ_IRQ_FLAG_BIT 2

// Instruction cycle is four oscillator periods
`define TMZ_CYCLE_DIV 2'h3
`define TMZ_WRITE_HOLD 2'h2

`endif

// *** tmz_pkg.sv ***
// Types shared by the timer block
package tmz_pkg;

    typedef struct packed {
        logic run_control;
        logic width_select;
        logic count_source_select;
        logic source_edge_select;
        logic prescaler_bypass;
        logic [2:0] prescale_ratio_select;
    } tmz_ctrl_t;

    typedef enum logic [1:0] {
        TMZ_IDLE = 2'b00,
        TMZ_ACK = 2'b01
    } tmz_bus_st_t;

endpackage

// *** tb_tmz_timer.sv ***
// Self-checking bench for the prescaled timer/counter
`include "tmz_consts.svh"

module tb_tmz_timer;
timeunit 1ns;
timeprecision 1ps;

logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic cyc_i = 1'b0;
logic stb_i = 1'b0;
logic we_i = 1'b0;
logic [3:0] adr_i = 4'h0;
logic [3:0] sel_i = 4'hF;
logic [31:0] dat_i = 32'h0;
logic [31:0] dat_o;
logic ack_o;
logic pin_i = 1'b0;
logic sleep_i = 1'b0;
logic irq_o;
int n_errors = 0;
int n_checks = 0;
logic [8:0] note_q[$];
logic [8:0] note;
logic [7:0] last_rd = 8'h00;
logic [7:0] v;
int p;

always #12.5 clk_i = ~clk_i;

tmz_timer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .ext_count_pin_i(pin_i),
    .sleep_i(sleep_i), .overflow_irq_o(irq_o)
);

task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        n_errors++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask

task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////
// Read results are compared against the oldest note
always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && note_q.size() > 0) begin
        note = note_q.pop_front();
        last_rd <= dat_o[7:0];
        if (note[8]) begin
            chk(dat_o, {24'h0, note[7:0]});
        end
    end
end

// Fixed access length keeps the spacing of taken edges exact
task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                   input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, d};
    do begin
        @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
endtask

task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
endtask

task automatic rd(input logic [3:0] a, input logic e, input logic [7:0] x);
    note_q.push_back({e, x});
    bus(1'b0, a, 8'h00, 4'hF);
endtask

// Two low byte reads whose taken edges are gap+4 clocks apart
task automatic delta(input int gap, input logic [7:0] k);
    rd(`TMZ_ADR_LOW, 1'b0, 8'h00);
    repeat (gap) @(posedge clk_i);
    rd(`TMZ_ADR_LOW, 1'b1, last_rd + k);
endtask

task automatic done(input string s);
    $display("test %s done", s);
endtask

////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
end

initial begin
    void'($urandom(32'h2cd6));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TMZ_ADR_CTRL, 1'b1, 8'hFF);
    rd(`TMZ_ADR_IRQ, 1'b1, 8'h00);
    rd(`TMZ_ADR_HIGH, 1'b1, 8'h00);
    v = 8'($urandom());
    wr(`TMZ_ADR_CTRL, v);
    bus(1'b1, `TMZ_ADR_CTRL, ~v, 4'h0);
    rd(`TMZ_ADR_CTRL, 1'b1, v);
    wr(4'h2, v);
    rd(4'h2, 1'b1, 8'h00);
    done("registers");
    wr(`TMZ_ADR_CTRL, 8'hC8);
    delta(36, 8'd10);
    v = 8'($urandom());
    wr(`TMZ_ADR_LOW, v);
    repeat (17) @(posedge clk_i);
    rd(`TMZ_ADR_LOW, 1'b1, v + 8'd3);
    wr(`TMZ_ADR_CTRL, 8'h48);
    delta(36, 8'd0);
    wr(`TMZ_ADR_CTRL, 8'hC8);
    sleep_i <= 1'b1;
    delta(36, 8'd0);
    sleep_i <= 1'b0;
    done("timer");
    // Ratio 2 to 256; the window spans two prescaler periods
    for (int s = 0; s < 8; s++) begin
        wr(`TMZ_ADR_CTRL, {5'b11000, 3'(s)});
        delta(8 * (2 << s) - 4, 8'd2);
    end
    // Prescaler near 150 of 256 when the low byte write must clear it
    wr(`TMZ_ADR_CTRL, 8'h47);
    wr(`TMZ_ADR_LOW, 8'h00);
    wr(`TMZ_ADR_CTRL, 8'hC7);
    repeat (600) @(posedge clk_i);
    wr(`TMZ_ADR_LOW, 8'h00);
    repeat (600) @(posedge clk_i);
    rd(`TMZ_ADR_LOW, 1'b1, 8'h00);
    repeat (500) @(posedge clk_i);
    rd(`TMZ_ADR_LOW, 1'b1, 8'h01);
    done("prescaler");
    wr(`TMZ_ADR_CTRL, 8'h48);
    wr(`TMZ_ADR_IRQ, 8'h20);
    wr(`TMZ_ADR_LOW, 8'hFD);
    wr(`TMZ_ADR_CTRL, 8'hC8);
    repeat (40) @(posedge clk_i);
    rd(`TMZ_ADR_IRQ, 1'b1, 8'h24);
    chk({31'h0, irq_o}, 32'h1);
    wr(`TMZ_ADR_CTRL, 8'h48);
    wr(`TMZ_ADR_IRQ, 8'h04);
    chk({31'h0, irq_o}, 32'h0);
    wr(`TMZ_ADR_IRQ, 8'h20);
    rd(`TMZ_ADR_IRQ, 1'b1, 8'h20);
    for (int h = 0; h < 2; h++) begin
        wr(`TMZ_ADR_CTRL, 8'h08);
        wr(`TMZ_ADR_HIGH, h ? 8'hFF : 8'h00);
        wr(`TMZ_ADR_LOW, 8'hFD);
        wr(`TMZ_ADR_CTRL, 8'h88);
        repeat (40) @(posedge clk_i);
        rd(`TMZ_ADR_IRQ, 1'b1, h ? 8'h24 : 8'h20);
        wr(`TMZ_ADR_IRQ, 8'h20);
    end
    wr(`TMZ_ADR_CTRL, 8'h08);
    v = 8'($urandom());
    wr(`TMZ_ADR_HIGH, v);
    wr(`TMZ_ADR_LOW, 8'h3C);
    wr(`TMZ_ADR_HIGH, ~v);
    rd(`TMZ_ADR_LOW, 1'b1, 8'h3C);
    rd(`TMZ_ADR_HIGH, 1'b1, v);
    done("overflow");
    // Odd toggle count: the chosen edge occurs once more than the other
    for (int e = 0; e < 2; e++) begin
        pin_i <= 1'(e);
        wr(`TMZ_ADR_CTRL, e ? 8'hF8 : 8'hE8);
        repeat (12) @(posedge clk_i);
        rd(`TMZ_ADR_LOW, 1'b0, 8'h00);
        p = 3 + ($urandom() % 4);
        repeat (2 * p - 1) begin
            repeat (6) @(posedge clk_i);
            pin_i <= ~pin_i;
        end
        repeat (8) @(posedge clk_i);
        rd(`TMZ_ADR_LOW, 1'b1, last_rd + 8'(p));
    end
    done("counter");
    give_verdict();
end

endmodule // tb_tmz_timer
